/* shared/swdt_pkg.sv */
// Purpose: Constants and types shared by the watchdog block.
// Assumes: APB byte addresses are four times the printed register index.
// Notes: Timebase counts derive from the 10 MHz clock.
package swdt_pkg;
    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_TIMEBASE = 8'h52;
    localparam logic [7:0] IDX_PERIOD = 8'h53;
    localparam logic [7:0] IDX_SOURCES = 8'h54;
    localparam logic [7:0] IDX_CTRL = 8'h55;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h56;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h57;
    localparam logic [9:0] ADDR_TIMEBASE = {IDX_TIMEBASE, 2'b00};
    localparam logic [9:0] ADDR_PERIOD = {IDX_PERIOD, 2'b00};
    localparam logic [9:0] ADDR_SOURCES = {IDX_SOURCES, 2'b00};
    localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_SECONDS = 7;
    localparam int BIT_JOY_EN = 0;
    localparam int BIT_KBD_EN = 1;
    localparam int BIT_MOUSE_EN = 2;
    localparam int MAP_LSB = 4;
    localparam int BIT_STATUS = 0;
    localparam int BIT_FORCE = 2;
    localparam int BIT_KBC_EN = 3;
    localparam logic [7:0] RST_TIMEBASE = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'h00;
    localparam logic [7:0] RST_SOURCES = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [3:0] MAP_DISABLE = 4'h0;
    localparam logic [3:0] MAP_INVALID = 4'h2;
    localparam logic [7:0] PERIOD_OFF = 8'h00;
    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int SECOND_S = 1;
    localparam int MINUTE_S = 60;
    localparam int CYC_PER_SECOND = CLK_HZ * SECOND_S;
    localparam int SEC_PER_MINUTE = MINUTE_S / SECOND_S;
    typedef enum logic [1:0] {SWDT_IDLE, SWDT_RUN, SWDT_EXPIRED} swdt_state_t;
endpackage : swdt_pkg

/* logic/swdt_tick.sv */
// Purpose: Unit tick generator, one pulse per second or per minute.
// Assumes: restart is a one-cycle pulse in the mclk domain.
// Notes: Restart zeroes both prescalers so the first unit is whole.
`timescale 1ns/10ps
module swdt_tick #(
    parameter int CYC_PER_SECOND = swdt_pkg::CYC_PER_SECOND
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic restart,
    input wire logic seconds,
    output logic unit_tick
);
    logic [31:0] cyc_cnt;
    logic [5:0] sec_cnt;
    logic sec_tick;

    assign sec_tick = (cyc_cnt == 32'(CYC_PER_SECOND - 1));

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            cyc_cnt <= 32'h0;
        else if (restart || sec_tick)
            cyc_cnt <= 32'h0;
        else
            cyc_cnt <= cyc_cnt + 32'h1;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            sec_cnt <= 6'h0;
        else if (restart)
            sec_cnt <= 6'h0;
        else if (sec_tick)
            sec_cnt <= (sec_cnt == 6'(swdt_pkg::SEC_PER_MINUTE - 1)) ? 6'h0 : sec_cnt + 6'h1;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            unit_tick <= 1'b0;
        else
            unit_tick <= !restart && sec_tick &&
                (seconds || sec_cnt == 6'(swdt_pkg::SEC_PER_MINUTE - 1));
    end
endmodule : swdt_tick

/* logic/swdt_sync.sv */
// Purpose: Two-stage synchroniser with rising-edge pulse.
// Assumes: din is asynchronous to mclk.
// Notes: Edge detection reads only the second stage onward.
`timescale 1ns/10ps
module swdt_sync
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic din,
    output logic dout,
    output logic rise
);
    logic meta;
    logic last;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= 1'b0;
            dout <= 1'b0;
            last <= 1'b0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
            last <= dout;
        end
    end

    assign rise = dout && !last;
endmodule : swdt_sync

/* logic/swdt_top.sv */
// Purpose: System watchdog timer with APB register access.
// Assumes: Restart event inputs are one-cycle pulses from mclk-domain logic.
// Notes: The controller force pin is asynchronous and synchronised here.
// What this block does
// - Timebase bit: 0 minutes, 1 seconds
// - Period zero disables the watchdog
// - Period N expires after N units
// - Joystick port access restarts when enabled
// - Keyboard interrupt restarts when enabled
// - Mouse interrupt restarts when enabled
// - Mapping field routes interrupt to IRQ
// - Status reads 1 after timeout
// - Force bit triggers timeout, self-clears
// - Controller pin rising edge forces timeout
// - Edge pulse ORed with software force
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
module swdt_top #(
    parameter int CYC_PER_SECOND = swdt_pkg::CYC_PER_SECOND
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic joy_port_access,
    input wire logic kbd_irq,
    input wire logic mouse_irq,
    input wire logic kbc_force_output,
    output logic [15:0] irq_lines,
    output logic irq
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] watchdog_timebase_select;
    logic [7:0] watchdog_period;
    logic [7:0] watchdog_restart_sources;
    logic status_flag;
    logic kbc_force_en;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] count;
    swdt_pkg::swdt_state_t state;

    logic wr_en;
    logic rd_en;
    logic addr_hit;
    logic [9:0] waddr;
    logic sw_force;
    logic kbc_rise;
    logic pin_force;
    logic force_event;
    logic restart_event;
    logic period_write;
    logic reload;
    logic unit_tick;
    logic count_expire;
    logic timeout_event;
    logic status_clear;
    logic [3:0] irq_map;

    // Byte address; a nonzero top pair maps onto an odd address so nothing matches
    assign waddr = (paddr[11:10] == 2'b00) ? paddr[9:0] : 10'h3ff;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign addr_hit = (waddr == swdt_pkg::ADDR_TIMEBASE) || (waddr == swdt_pkg::ADDR_PERIOD) ||
        (waddr == swdt_pkg::ADDR_SOURCES) || (waddr == swdt_pkg::ADDR_CTRL) ||
        (waddr == swdt_pkg::ADDR_IRQ_STATUS) || (waddr == swdt_pkg::ADDR_IRQ_MASK);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    // ------------------------------------------------------------
    // Force sources
    // ------------------------------------------------------------
    swdt_sync u_kbc_sync
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .din(kbc_force_output),
        .dout(),
        .rise(kbc_rise)
    );

    assign pin_force = kbc_rise && kbc_force_en;
    assign sw_force = wr_en && (waddr == swdt_pkg::ADDR_CTRL) && pwdata[swdt_pkg::BIT_FORCE];
    assign force_event = sw_force || pin_force;

    // ------------------------------------------------------------
    // Restart sources
    // ------------------------------------------------------------
    // gated restarts
    assign restart_event =
        (joy_port_access && watchdog_restart_sources[swdt_pkg::BIT_JOY_EN]) ||
        (kbd_irq && watchdog_restart_sources[swdt_pkg::BIT_KBD_EN]) ||
        (mouse_irq && watchdog_restart_sources[swdt_pkg::BIT_MOUSE_EN]);
    assign period_write = wr_en && (waddr == swdt_pkg::ADDR_PERIOD);
    assign reload = restart_event || period_write;

    swdt_tick #(
        .CYC_PER_SECOND(CYC_PER_SECOND)
    )
    u_tick
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .restart(reload),
        .seconds(watchdog_timebase_select[swdt_pkg::BIT_SECONDS]),
        .unit_tick(unit_tick)
    );

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            watchdog_timebase_select <= swdt_pkg::RST_TIMEBASE;
        else if (wr_en && waddr == swdt_pkg::ADDR_TIMEBASE)
            watchdog_timebase_select <= {pwdata[swdt_pkg::BIT_SECONDS], 7'h00};
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            watchdog_period <= swdt_pkg::RST_PERIOD;
        else if (period_write)
            watchdog_period <= pwdata[7:0];
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            watchdog_restart_sources <= swdt_pkg::RST_SOURCES;
        else if (wr_en && waddr == swdt_pkg::ADDR_SOURCES)
            watchdog_restart_sources <= {pwdata[7:4], 1'b0, pwdata[2:0]};
    end

    // Reserved upper control bits are not stored, so a stray one is harmless
    // reserved bits dropped
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            kbc_force_en <= swdt_pkg::RST_CTRL[swdt_pkg::BIT_KBC_EN];
        else if (wr_en && waddr == swdt_pkg::ADDR_CTRL)
            kbc_force_en <= pwdata[swdt_pkg::BIT_KBC_EN];
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    assign count_expire = (state == swdt_pkg::SWDT_RUN) && unit_tick && (count == 8'h01) && !reload;
    assign timeout_event = count_expire || force_event;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= swdt_pkg::SWDT_IDLE;
            count <= 8'h00;
        end
        else if (reload)
        begin
            count <= period_write ? pwdata[7:0] : watchdog_period;
            state <= ((period_write ? pwdata[7:0] : watchdog_period) == swdt_pkg::PERIOD_OFF) ?
                swdt_pkg::SWDT_IDLE : swdt_pkg::SWDT_RUN;
        end
        else
        begin
            unique case (state)
                swdt_pkg::SWDT_IDLE:
                begin
                    if (force_event)
                        state <= swdt_pkg::SWDT_EXPIRED;
                end
                swdt_pkg::SWDT_RUN:
                begin
                    if (timeout_event)
                    begin
                        state <= swdt_pkg::SWDT_EXPIRED;
                        count <= 8'h00;
                    end
                    else if (unit_tick)
                        count <= count - 8'h01;
                end
                swdt_pkg::SWDT_EXPIRED:
                begin
                    state <= swdt_pkg::SWDT_EXPIRED;
                end
                default:
                    state <= swdt_pkg::SWDT_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status and interrupts
    // ------------------------------------------------------------
    assign status_clear = wr_en && (waddr == swdt_pkg::ADDR_CTRL) && !pwdata[swdt_pkg::BIT_STATUS];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            status_flag <= swdt_pkg::RST_CTRL[swdt_pkg::BIT_STATUS];
        else if (timeout_event)
            status_flag <= 1'b1;
        else if (wr_en && waddr == swdt_pkg::ADDR_CTRL)
            status_flag <= pwdata[swdt_pkg::BIT_STATUS];
    end

    // Bit 0 timeout, bit 1 restart seen; write one to clear, set wins
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            irq_status <= 2'h0;
        else
            irq_status <= (irq_status & ~((wr_en && waddr == swdt_pkg::ADDR_IRQ_STATUS) ? pwdata[1:0] : 2'h0))
                | {restart_event, timeout_event};
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            irq_mask <= 2'h0;
        else if (wr_en && waddr == swdt_pkg::ADDR_IRQ_MASK)
            irq_mask <= pwdata[1:0];
    end

    assign irq = |(irq_status & irq_mask);
    assign irq_map = watchdog_restart_sources[7:4];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            irq_lines <= 16'h0000;
        else if (status_flag && irq_map != swdt_pkg::MAP_DISABLE && irq_map != swdt_pkg::MAP_INVALID)
            irq_lines <= 16'h0001 << irq_map;
        else
            irq_lines <= 16'h0000;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
        begin
            unique case (waddr)
                swdt_pkg::ADDR_TIMEBASE: prdata <= {24'h0, watchdog_timebase_select};
                swdt_pkg::ADDR_PERIOD: prdata <= {24'h0, watchdog_period};
                swdt_pkg::ADDR_SOURCES: prdata <= {24'h0, watchdog_restart_sources};
                swdt_pkg::ADDR_CTRL: prdata <= {28'h0, kbc_force_en, 2'b00, status_flag};
                swdt_pkg::ADDR_IRQ_STATUS: prdata <= {30'h0, irq_status};
                swdt_pkg::ADDR_IRQ_MASK: prdata <= {30'h0, irq_mask};
                default: prdata <= 32'h0;
            endcase
        end
    end
endmodule : swdt_top

/* tb/swdt_checker.sv */
// Purpose: Port checks for the watchdog top.
// Assumes: Map is not rewritten while a line is up.
// Notes: Shadows follow map and pin-enable writes.
`timescale 1ns/10ps
module swdt_checker #(
    parameter int CYC_PER_SECOND = 10
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic joy_port_access,
    input wire logic kbd_irq,
    input wire logic mouse_irq,
    input wire logic kbc_force_output,
    input wire logic [15:0] irq_lines,
    input wire logic irq
);
    logic [3:0] map_q;
    logic pin_en_q;
    logic acc;
    logic wr_ctrl;
    logic clr;
    logic map_ok;
    assign acc = psel && penable;
    assign wr_ctrl = acc && pwrite && paddr == {2'b00, swdt_pkg::ADDR_CTRL};
    assign clr = wr_ctrl && !pwdata[0] && !pwdata[2];
    assign map_ok = map_q != swdt_pkg::MAP_DISABLE && map_q != swdt_pkg::MAP_INVALID;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            map_q <= 4'h0;
        else if (acc && pwrite && paddr == {2'b00, swdt_pkg::ADDR_SOURCES})
            map_q <= pwdata[7:4];
    end
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            pin_en_q <= 1'b0;
        else if (wr_ctrl)
            pin_en_q <= pwdata[3];
    end
    // ------
    // Properties
    // ------
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    sequence s_line_up;
        irq_lines == 16'h0001 << map_q;
    endsequence
    a_force_line: assert property (wr_ctrl && pwdata[2] && map_ok |-> ##[1:4] s_line_up)
        else $error("force write left the mapped line low");
    a_pin_line: assert property ($rose(kbc_force_output) && pin_en_q && map_ok |-> ##[1:8] s_line_up)
        else $error("pin edge left the mapped line low");
    a_lines_onehot: assert property ($onehot0(irq_lines))
        else $error("more than one line up");
    a_lines_invalid: assert property (irq_lines[0] == 1'b0 && irq_lines[2] == 1'b0)
        else $error("disabled or invalid code drove a line");
    a_force_reads_zero: assert property (acc && !pwrite && paddr == {2'b00, swdt_pkg::ADDR_CTRL}
        |-> prdata[2] == 1'b0 && prdata[7:4] == 4'h0)
        else $error("force or reserved control bit read back set");
    a_units_read: assert property (acc && !pwrite && paddr == {2'b00, swdt_pkg::ADDR_TIMEBASE}
        |-> prdata[6:0] == 7'h00)
        else $error("reserved unit bits read back set");
    a_clear_drops: assert property (clr |-> ##3 irq_lines == 16'h0000)
        else $error("line stayed up after status clear");
    a_lines_hold: assert property ($fell(|irq_lines) |-> $past(clr, 1) || $past(clr, 2) || $past(clr, 3))
        else $error("line fell without a status clear");
endmodule : swdt_checker

bind swdt_top swdt_checker #(.CYC_PER_SECOND(CYC_PER_SECOND)) swdt_checker_inst (.mclk(mclk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .joy_port_access(joy_port_access), .kbd_irq(kbd_irq),
    .mouse_irq(mouse_irq), .kbc_force_output(kbc_force_output), .irq_lines(irq_lines), .irq(irq));

/* tb/swdt_far_model.sv */
// Purpose: Game port, keyboard, mouse and controller pin model.
// Assumes: Event pulses last one mclk cycle.
// Notes: Once raised the pin stays high ten cycles at least.
`timescale 1ns/10ps
module swdt_far_model
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ev_go,
    input wire logic [1:0] ev_sel,
    input wire logic pin_req,
    output logic joy_port_access,
    output logic kbd_irq,
    output logic mouse_irq,
    output logic kbc_force_output
);
    logic [3:0] hold;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            joy_port_access <= 1'b0;
            kbd_irq <= 1'b0;
            mouse_irq <= 1'b0;
        end
        else
        begin
            joy_port_access <= ev_go && ev_sel == 2'd0;
            kbd_irq <= ev_go && ev_sel == 2'd1;
            mouse_irq <= ev_go && ev_sel == 2'd2;
        end
    end
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            hold <= 4'h0;
        else if (pin_req && !kbc_force_output)
            hold <= 4'h9;
        else if (hold != 4'h0)
            hold <= hold - 4'h1;
    end
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            kbc_force_output <= 1'b0;
        else
            kbc_force_output <= pin_req || hold != 4'h0;
    end
endmodule : swdt_far_model

/* tb/swdt_top_tb.sv */
// Purpose: Register-level tests of the watchdog top.
// Assumes: A unit second is CPS cycles.
// Notes: A short second keeps every count inside the run.
`timescale 1ns/10ps
module swdt_top_tb;
    localparam int CPS = 10;
    localparam logic [11:0] A_UNIT = {2'b00, swdt_pkg::ADDR_TIMEBASE};
    localparam logic [11:0] A_PER = {2'b00, swdt_pkg::ADDR_PERIOD};
    localparam logic [11:0] A_SRC = {2'b00, swdt_pkg::ADDR_SOURCES};
    localparam logic [11:0] A_CTRL = {2'b00, swdt_pkg::ADDR_CTRL};
    localparam logic [11:0] A_IST = {2'b00, swdt_pkg::ADDR_IRQ_STATUS};
    localparam logic [11:0] A_IMSK = {2'b00, swdt_pkg::ADDR_IRQ_MASK};
    logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, irq, ev_go, pin_req, rerr;
    logic joy_port_access, kbd_irq, mouse_irq, kbc_force_output;
    logic [1:0] ev_sel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [15:0] irq_lines;
    int mismatches, check_count;
    swdt_top #(.CYC_PER_SECOND(CPS)) swdt_top_inst (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .joy_port_access(joy_port_access), .kbd_irq(kbd_irq), .mouse_irq(mouse_irq),
        .kbc_force_output(kbc_force_output), .irq_lines(irq_lines), .irq(irq));
    swdt_far_model swdt_far_model_inst (.mclk(mclk), .arst_n(arst_n), .ev_go(ev_go), .ev_sel(ev_sel),
        .pin_req(pin_req), .joy_port_access(joy_port_access), .kbd_irq(kbd_irq), .mouse_irq(mouse_irq),
        .kbc_force_output(kbc_force_output));
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Read data and error are taken only at the edge that sees ready high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge mclk);
            if (pready === 1'b1)
            begin
                rdata = prdata;
                rerr = pslverr;
                break;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20)
        begin
            mismatches++;
            end_of_test();
        end
    endtask : xfer
    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask : settle
    task automatic timed(input logic [7:0] unit, input logic [7:0] per, input logic [7:0] src,
        input logic [1:0] ev, input int at, input int exp);
        int n;
        xfer(1'b1, A_CTRL, 32'h0);
        xfer(1'b1, A_IST, 32'h3);
        xfer(1'b1, A_UNIT, {24'h0, unit});
        xfer(1'b1, A_SRC, {24'h0, src});
        ev_sel <= ev;
        xfer(1'b1, A_PER, {24'h0, per});
        for (n = 0; n < 3000; n++)
        begin
            @(negedge mclk);
            if (irq === 1'b1)
                break;
            @(posedge mclk);
            ev_go <= (n == at);
        end
        if (n == 3000)
        begin
            mismatches++;
            end_of_test();
        end
        chk(32'(n > exp - 4 && n < exp + 4), 32'h1);
        xfer(1'b0, A_CTRL, 32'h0);
        chk(rdata, 32'h1);
    endtask : timed
    initial
    begin
        logic [3:0] maps [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hf};
        {arst_n, psel, penable, pwrite, ev_go, pin_req, ev_sel, paddr, pwdata} = '0;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            xfer(1'b0, A_UNIT + 12'(4 * i), 32'h0);
            chk(rdata, 32'h0);
        end
        xfer(1'b0, 12'h14a, 32'h0);
        chk({rerr, rdata[30:0]}, 32'h8000_0000);
        xfer(1'b1, A_UNIT, 32'hff);
        xfer(1'b0, A_UNIT, 32'h0);
        chk(rdata, 32'h80);
        xfer(1'b1, A_IMSK, 32'h1);
        xfer(1'b1, A_PER, 32'h0);
        settle(700);
        chk({31'h0, irq}, 32'h0);
        timed(8'h80, 8'd3, 8'h0, 2'd0, 9999, 31);
        timed(8'h80, 8'd1, 8'h0, 2'd0, 9999, 11);
        timed(8'h00, 8'd1, 8'h0, 2'd0, 9999, 601);
        timed(8'h80, 8'hff, 8'h0, 2'd0, 9999, 2551);
        for (int e = 0; e < 3; e++)
        begin
            timed(8'h80, 8'd3, 8'(1 << e), 2'(e), 15, 49);
            timed(8'h80, 8'd3, 8'(7 & ~(1 << e)), 2'(e), 15, 31);
        end
        xfer(1'b1, A_IMSK, 32'h0);
        settle(1);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, A_IMSK, 32'h1);
        settle(1);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, A_IST, 32'h1);
        settle(1);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, A_PER, 32'h0);
        foreach (maps[k])
        begin
            xfer(1'b1, A_SRC, {24'h0, maps[k], 4'h0});
            // reserved control bits written as zero
            xfer(1'b1, A_CTRL, 32'h4);
            settle(4);
            chk({16'h0, irq_lines}, (maps[k] == 4'h0 || maps[k] == 4'h2) ? 32'h0 : 32'h1 << maps[k]);
            xfer(1'b0, A_CTRL, 32'h0);
            chk(rdata, 32'h1);
            xfer(1'b1, A_CTRL, 32'h0);
            settle(4);
            chk({16'h0, irq_lines}, 32'h0);
        end
        pin_req <= 1'b1;
        settle(8);
        xfer(1'b0, A_CTRL, 32'h0);
        chk(rdata, 32'h0);
        pin_req <= 1'b0;
        settle(12);
        xfer(1'b1, A_CTRL, 32'h8);
        pin_req <= 1'b1;
        settle(8);
        xfer(1'b0, A_CTRL, 32'h0);
        chk(rdata, 32'h9);
        xfer(1'b1, A_CTRL, 32'h8);
        settle(8);
        xfer(1'b0, A_CTRL, 32'h0);
        chk(rdata, 32'h8);
        xfer(1'b1, A_CTRL, 32'hc);
        settle(4);
        xfer(1'b0, A_CTRL, 32'h0);
        chk(rdata, 32'h9);
        pin_req <= 1'b0;
        end_of_test();
    end
endmodule : swdt_top_tb
